// *** tsp_regs.svh ***
// Constants for the time serial ports and supervision lamps block.
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
`define TSP_CLK_HZ 100000000
`define TSP_BAUD_1200 1200
`define TSP_BAUD_2400 2400
`define TSP_BAUD_4800 4800
`define TSP_BAUD_9600 9600
`define TSP_SUP_MAX_S 86399
`define TSP_LOCK_DEF_S 900
`define TSP_SYNC_DEF_S 7200
`define TSP_MARK_TOL_FINE_US 100
`define TSP_MARK_TOL_COARSE_US 1000
`define TSP_FMT_CNT 6
`define TSP_DEF_QUERY_CHAR 8'h54
`endif

// *** tsp_pkg.sv ***
// Types shared by the time serial ports block.
`default_nettype none
package tsp_pkg;
    typedef enum logic [1:0] {
        TSP_B1200 = 2'h0,
        TSP_B2400 = 2'h1,
        TSP_B4800 = 2'h2,
        TSP_B9600 = 2'h3
    } tsp_baud_t;
    typedef enum logic [2:0] {
        TSP_FMT0 = 3'h0,
        TSP_FMT1 = 3'h1,
        TSP_FMT2 = 3'h2,
        TSP_FMT3 = 3'h3,
        TSP_FMT4 = 3'h4,
        TSP_FMT90 = 3'h5
    } tsp_fmt_t;
    typedef enum logic [1:0] {
        TSP_IDLE = 2'h0,
        TSP_START = 2'h1,
        TSP_DATA = 2'h3,
        TSP_STOP = 2'h2
    } tsp_line_t;
endpackage
`default_nettype wire

// *** tsp_uart.sv ***
// One serial port: a transmitter, and a receiver for the query character.
`default_nettype none
`include "tsp_regs.svh"
module tsp_uart
    import tsp_pkg::*;
#(
    parameter int CLK_HZ = `TSP_CLK_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire tsp_baud_t baud_sel,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic txd,
    input wire logic rxd,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    localparam int DIV_W = 17;
    localparam logic [DIV_W-1:0] DIV1200 = DIV_W'(CLK_HZ / `TSP_BAUD_1200);
    localparam logic [DIV_W-1:0] DIV2400 = DIV_W'(CLK_HZ / `TSP_BAUD_2400);
    localparam logic [DIV_W-1:0] DIV4800 = DIV_W'(CLK_HZ / `TSP_BAUD_4800);
    localparam logic [DIV_W-1:0] DIV9600 = DIV_W'(CLK_HZ / `TSP_BAUD_9600);

    function automatic logic [DIV_W-1:0] bit_cycles(input tsp_baud_t b);
        case (b)
            TSP_B1200: bit_cycles = DIV1200;
            TSP_B2400: bit_cycles = DIV2400;
            TSP_B4800: bit_cycles = DIV4800;
            default: bit_cycles = DIV9600;
        endcase
    endfunction

    typedef struct packed {
        tsp_line_t tst;
        logic [DIV_W-1:0] tcnt;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic txd;
        tsp_line_t rst_;
        logic [DIV_W-1:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic [7:0] rdat;
        logic rvld;
    } tsp_uart_st_t;

    tsp_uart_st_t s_q, s_d;
    logic [DIV_W-1:0] per;

    always_comb begin
        per = bit_cycles(baud_sel);
        s_d = s_q;
        s_d.rvld = 1'b0;
        // ---------------------------------------------------------------
        // Transmitter
        // ---------------------------------------------------------------
        // RULE8 10-bit 8N1 frame
        case (s_q.tst)
            TSP_IDLE: begin
                // RULE14 idle at mark
                s_d.txd = 1'b1;
                if (tx_valid) begin
                    s_d.tsh = tx_data;
                    s_d.tst = TSP_START;
                    s_d.tcnt = per - 1'b1;
                    s_d.txd = 1'b0;
                end
            end
            TSP_START: begin
                if (s_q.tcnt == '0) begin
                    s_d.tst = TSP_DATA;
                    s_d.tcnt = per - 1'b1;
                    s_d.tbit = 3'h0;
                    // RULE14 LSB first
                    s_d.txd = s_q.tsh[0];
                    s_d.tsh = {1'b0, s_q.tsh[7:1]};
                end else begin
                    s_d.tcnt = s_q.tcnt - 1'b1;
                end
            end
            TSP_DATA: begin
                if (s_q.tcnt == '0) begin
                    s_d.tcnt = per - 1'b1;
                    if (s_q.tbit == 3'h7) begin
                        s_d.tst = TSP_STOP;
                        s_d.txd = 1'b1;
                    end else begin
                        s_d.tbit = s_q.tbit + 1'b1;
                        s_d.txd = s_q.tsh[0];
                        s_d.tsh = {1'b0, s_q.tsh[7:1]};
                    end
                end else begin
                    s_d.tcnt = s_q.tcnt - 1'b1;
                end
            end
            default: begin
                if (s_q.tcnt == '0) begin
                    s_d.tst = TSP_IDLE;
                end else begin
                    s_d.tcnt = s_q.tcnt - 1'b1;
                end
            end
        endcase
        // ---------------------------------------------------------------
        // Receiver, sampling mid-bit
        // ---------------------------------------------------------------
        case (s_q.rst_)
            TSP_IDLE: begin
                if (!rxd) begin
                    s_d.rst_ = TSP_START;
                    s_d.rcnt = {1'b0, per[DIV_W-1:1]};
                end
            end
            TSP_START: begin
                if (s_q.rcnt == '0) begin
                    s_d.rst_ = rxd ? TSP_IDLE : TSP_DATA;
                    s_d.rcnt = per - 1'b1;
                    s_d.rbit = 3'h0;
                end else begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end
            end
            TSP_DATA: begin
                if (s_q.rcnt == '0) begin
                    s_d.rsh = {rxd, s_q.rsh[7:1]};
                    s_d.rcnt = per - 1'b1;
                    s_d.rbit = s_q.rbit + 1'b1;
                    if (s_q.rbit == 3'h7) begin
                        s_d.rst_ = TSP_STOP;
                    end
                end else begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end
            end
            default: begin
                if (s_q.rcnt == '0) begin
                    s_d.rst_ = TSP_IDLE;
                    // A framing error drops the character silently.
                    if (rxd) begin
                        s_d.rdat = s_q.rsh;
                        s_d.rvld = 1'b1;
                    end
                end else begin
                    s_d.rcnt = s_q.rcnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{tst: TSP_IDLE, tcnt: '0, tbit: 3'h0, tsh: 8'h00, txd: 1'b1,
                     rst_: TSP_IDLE, rcnt: '0, rbit: 3'h0, rsh: 8'h00, rdat: 8'h00,
                     rvld: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_ready = (s_q.tst == TSP_IDLE);
    assign txd = s_q.txd;
    assign rx_data = s_q.rdat;
    assign rx_valid = s_q.rvld;
endmodule
`default_nettype wire

// *** tsp_top.sv ***
// Time data serial ports with lock and sync supervision lamps.
`default_nettype none
`include "tsp_regs.svh"
// Functional notes
// RULE1 - Lock lamp green if tracked within period
// RULE2 - Lock lamp red at startup or alarms
// RULE3 - Lock period seconds, max 23:59:59, default 15min
// RULE4 - Sync lamp green if tracked within period
// RULE5 - Sync lamp red at startup or alarm
// RULE6 - Sync period seconds, max 23:59:59, default 2h
// RULE7 - RS-232 sends on query or each second
// RULE8 - Characters framed 8N1, no parity
// RULE9 - Per-port baud 1200 to 9600
// RULE10 - Six formats; RS-232 zone, DST, query char
// RULE11 - No flow control on RS-232
// RULE12 - On-time marker aligned to second
// RULE13 - RS-485 sends every second unprompted
// RULE14 - Idle mark, LSB first
// RULE15 - Timers restart on track, alarm at period
module tsp_top
    import tsp_pkg::*;
#(
    parameter int NPORT = 4,
    parameter int N232 = 2,
    parameter int CLK_HZ = `TSP_CLK_HZ,
    parameter int MSG_LEN = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sec_tick,
    input wire logic sat_tracked,
    input wire logic cpu_alarm,
    input wire logic [16:0] lock_period_s,
    input wire logic [16:0] sync_period_s,
    input wire logic [2*NPORT-1:0] baud_sel,
    input wire logic [3*NPORT-1:0] fmt_sel,
    input wire logic [N232-1:0] continuous,
    input wire logic [8*N232-1:0] query_char,
    input wire logic [5*N232-1:0] zone_offset,
    input wire logic [2*N232-1:0] daylight_saving_rule,
    input wire logic [8*MSG_LEN-1:0] msg_bytes,
    input wire logic [N232-1:0] rxd,
    output logic [NPORT-1:0] txd,
    output logic [NPORT-1:0] msg_active,
    output logic [3*NPORT-1:0] msg_fmt,
    output logic [5*NPORT-1:0] msg_zone,
    output logic [2*NPORT-1:0] msg_dst,
    output logic lock_lamp_green,
    output logic lock_lamp_red,
    output logic sync_lamp_green,
    output logic sync_lamp_red,
    output logic lock_supervision_alarm,
    output logic sync_supervision_alarm
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [16:0] lock_cnt;
        logic [16:0] sync_cnt;
        logic lock_seen;
        logic sync_seen;
        logic lock_alm;
        logic sync_alm;
        logic [NPORT-1:0] busy;
        logic [NPORT-1:0] pend;
        logic [NPORT-1:0][3:0] idx;
        logic [NPORT-1:0][2:0] fmt;
        logic [NPORT-1:0][4:0] zone;
        logic [NPORT-1:0][1:0] dst;
    } tsp_top_st_t;

    tsp_top_st_t s_q, s_d;
    logic [NPORT-1:0] tx_ready;
    logic [NPORT-1:0] tx_valid;
    logic [NPORT-1:0][7:0] tx_byte;
    logic [N232-1:0][7:0] rx_data;
    logic [N232-1:0] rx_valid;

    // Clamps a programmed period to the 23:59:59 ceiling and at least one second.
    function automatic logic [16:0] clamp_period(input logic [16:0] p);
        if (p > 17'(`TSP_SUP_MAX_S)) begin
            clamp_period = 17'(`TSP_SUP_MAX_S);
        end else if (p == 17'h00000) begin
            clamp_period = 17'h00001;
        end else begin
            clamp_period = p;
        end
    endfunction

    function automatic logic [7:0] msg_byte(input logic [3:0] i, input logic [8*MSG_LEN-1:0] m);
        msg_byte = m[8*i +: 8];
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // RULE15 restart on tracking
        if (sat_tracked) begin
            s_d.lock_cnt = 17'h00000;
            s_d.sync_cnt = 17'h00000;
            s_d.lock_seen = 1'b1;
            s_d.sync_seen = 1'b1;
            s_d.lock_alm = 1'b0;
            s_d.sync_alm = 1'b0;
        end else if (sec_tick) begin
            // RULE3 lock period count
            if (s_q.lock_cnt + 17'h00001 >= clamp_period(lock_period_s)) begin
                s_d.lock_alm = 1'b1;
            end else begin
                s_d.lock_cnt = s_q.lock_cnt + 17'h00001;
            end
            // RULE6 sync period count
            if (s_q.sync_cnt + 17'h00001 >= clamp_period(sync_period_s)) begin
                s_d.sync_alm = 1'b1;
            end else begin
                s_d.sync_cnt = s_q.sync_cnt + 17'h00001;
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            // RULE10 latch per-port options
            if (!s_q.busy[p]) begin
                s_d.fmt[p] = fmt_sel[3*p +: 3];
                s_d.zone[p] = (p < N232) ? zone_offset[5*(p%N232) +: 5] : 5'h00;
                s_d.dst[p] = (p < N232) ? daylight_saving_rule[2*(p%N232) +: 2] : 2'h0;
            end
            // RULE7 query starts a message at next second
            if (p < N232 && rx_valid[p%N232] &&
                rx_data[p%N232] == query_char[8*(p%N232) +: 8]) begin
                s_d.pend[p] = 1'b1;
            end
            // RULE12 start exactly on the second mark
            if (sec_tick && !s_q.busy[p]) begin
                // RULE13 periodic on remote ports
                if (p >= N232 || continuous[p%N232] || s_d.pend[p]) begin
                    s_d.busy[p] = 1'b1;
                    s_d.idx[p] = 4'h0;
                    s_d.pend[p] = 1'b0;
                end
            end else if (s_q.busy[p] && tx_ready[p]) begin
                // The port stays busy until the last character's stop bit has ended,
                // so the line never shows a character while the port reads as idle.
                if (s_q.idx[p] == 4'(MSG_LEN)) begin
                    s_d.busy[p] = 1'b0;
                end else begin
                    s_d.idx[p] = s_q.idx[p] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            // RULE11 no handshake lines; pacing is the baud timer only
            assign tx_valid[g] = s_q.busy[g] && tx_ready[g] && (s_q.idx[g] != 4'(MSG_LEN));
            assign tx_byte[g] = msg_byte(s_q.idx[g], msg_bytes);
            assign msg_active[g] = s_q.busy[g];
            assign msg_fmt[3*g +: 3] = s_q.fmt[g];
            assign msg_zone[5*g +: 5] = s_q.zone[g];
            assign msg_dst[2*g +: 2] = s_q.dst[g];
            if (g < N232) begin : g_232
                // RULE9 per-port baud
                tsp_uart #(.CLK_HZ(CLK_HZ)) u_uart (
                    .clk(clk),
                    .rst(rst),
                    .baud_sel(tsp_baud_t'(baud_sel[2*g +: 2])),
                    .tx_data(tx_byte[g]),
                    .tx_valid(tx_valid[g]),
                    .tx_ready(tx_ready[g]),
                    .txd(txd[g]),
                    .rxd(rxd[g]),
                    .rx_data(rx_data[g]),
                    .rx_valid(rx_valid[g])
                );
            end else begin : g_485
                // The remote ports have no receive side; the line is held at mark.
                tsp_uart #(.CLK_HZ(CLK_HZ)) u_uart (
                    .clk(clk),
                    .rst(rst),
                    .baud_sel(tsp_baud_t'(baud_sel[2*g +: 2])),
                    .tx_data(tx_byte[g]),
                    .tx_valid(tx_valid[g]),
                    .tx_ready(tx_ready[g]),
                    .txd(txd[g]),
                    .rxd(1'b1),
                    .rx_data(),
                    .rx_valid()
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Lamps
    // ------------------------------------------------------------------
    // RULE1 lock green
    assign lock_lamp_green = s_q.lock_seen && !s_q.lock_alm && !cpu_alarm;
    // RULE2 lock red
    assign lock_lamp_red = !lock_lamp_green;
    // RULE4 sync green
    assign sync_lamp_green = s_q.sync_seen && !s_q.sync_alm;
    // RULE5 sync red
    assign sync_lamp_red = !sync_lamp_green;
    assign lock_supervision_alarm = s_q.lock_alm;
    assign sync_supervision_alarm = s_q.sync_alm;
endmodule
`default_nettype wire

// *** tsp_top_sva.sv ***
// Assertion checker for the time serial ports and supervision lamps.
`default_nettype none
module tsp_top_sva #(
    parameter int NPORT = 4,
    parameter int N232 = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sec_tick,
    input wire logic sat_tracked,
    input wire logic cpu_alarm,
    input wire logic [N232-1:0] continuous,
    input wire logic [NPORT-1:0] txd,
    input wire logic [NPORT-1:0] msg_active,
    input wire logic [3*NPORT-1:0] msg_fmt,
    input wire logic lock_lamp_green,
    input wire logic lock_lamp_red,
    input wire logic sync_lamp_green,
    input wire logic sync_lamp_red,
    input wire logic lock_supervision_alarm,
    input wire logic sync_supervision_alarm
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_lock_red: assert property ((cpu_alarm || lock_supervision_alarm) |->
        lock_lamp_red && !lock_lamp_green) else $error("lock lamp not red on alarm");
    a_sync_red: assert property (sync_supervision_alarm |->
        sync_lamp_red && !sync_lamp_green) else $error("sync lamp not red on alarm");
    a_track_green: assert property (sat_tracked |=>
        sync_lamp_green && !lock_supervision_alarm) else $error("no green after track");
    a_alarm_tick: assert property ($rose(sync_supervision_alarm) |->
        $past(sec_tick) && !$past(sat_tracked)) else $error("alarm raised off tick");
    a_idle_mark: assert property (&(txd | msg_active))
        else $error("line not at mark while idle");
    a_remote_sec: assert property (sec_tick && !msg_active[2] |=> msg_active[2])
        else $error("remote port missed second");
    a_cont_sec: assert property (sec_tick && continuous[0] && !msg_active[0]
        |=> msg_active[0]) else $error("continuous port missed second");
    a_query_tick: assert property ($rose(msg_active[1]) |-> $past(sec_tick))
        else $error("query answer off second mark");
    a_start_bit: assert property ($rose(msg_active[3]) |=> !txd[3] ##1 !txd[3])
        else $error("start bit missing");
    a_fmt_hold: assert property (msg_active[0] && $past(msg_active[0]) |->
        $stable(msg_fmt[2:0])) else $error("format changed mid message");
endmodule
`default_nettype wire

// *** tsp_far_end.sv ***
// Far-end serial terminal: decodes one output line and can send a query.
`default_nettype none
module tsp_far_end #(
    parameter int BIT = 10
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic [15:0] rx_last,
    output logic [7:0] rx_cnt,
    output logic ferr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] b;
    initial begin
        rxd = 1'b1;
        rx_last = 16'h0000;
        rx_cnt = 8'h00;
        ferr = 1'b0;
    end
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        if (txd !== 1'b0) ferr = 1'b1;
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        if (txd !== 1'b1) ferr = 1'b1;
        rx_last = {b, rx_last[15:8]};
        rx_cnt = rx_cnt + 8'h01;
    end
    // sent with no handshake; line rests at mark.
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// *** tsp_top_tb_top.sv ***
// Self-checking testbench for the time serial ports block.
`default_nettype none
`include "tsp_regs.svh"
`define CHK(nm, g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tsp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // A slow clock figure keeps bit times at 10 to 80 cycles.
    localparam int CLK = 96000;
    logic clk, rst, sec_tick, sat_tracked, cpu_alarm;
    logic [16:0] lock_period_s, sync_period_s;
    logic [7:0] baud_sel;
    logic [11:0] fmt_sel;
    logic [1:0] continuous, rxd;
    logic [15:0] query_char, msg_bytes;
    logic [9:0] zone_offset;
    logic [3:0] daylight_saving_rule, txd, msg_active, rxo;
    logic [11:0] msg_fmt;
    logic [19:0] msg_zone;
    logic [7:0] msg_dst;
    logic lock_lamp_green, lock_lamp_red, sync_lamp_green, sync_lamp_red;
    logic lock_supervision_alarm, sync_supervision_alarm;
    logic [15:0] rx_last [4];
    logic [7:0] rx_cnt [4];
    logic ferr [4];
    int fails, checks;
    int exp_cnt [4];
    tsp_top #(.CLK_HZ(CLK), .MSG_LEN(2)) tsp_top_inst (.clk, .rst, .sec_tick,
        .sat_tracked, .cpu_alarm, .lock_period_s, .sync_period_s, .baud_sel, .fmt_sel,
        .continuous, .query_char, .zone_offset, .daylight_saving_rule, .msg_bytes, .rxd,
        .txd, .msg_active, .msg_fmt, .msg_zone, .msg_dst, .lock_lamp_green,
        .lock_lamp_red, .sync_lamp_green, .sync_lamp_red, .lock_supervision_alarm,
        .sync_supervision_alarm);
    for (genvar k = 0; k < 4; k++) begin : g_far
        tsp_far_end #(.BIT(10 << k)) u_far (.clk(clk), .txd(txd[k]), .rxd(rxo[k]),
            .rx_last(rx_last[k]), .rx_cnt(rx_cnt[k]), .ferr(ferr[k]));
    end
    assign rxd = rxo[1:0];
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One second mark; q says whether the query port owes an answer.
    task automatic tick(input bit q);
        sec_tick <= 1'b1;
        @(posedge clk);
        sec_tick <= 1'b0;
        repeat (1999) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            if (k != 1 || q) exp_cnt[k] += 2;
            `CHK("rx_cnt", rx_cnt[k], exp_cnt[k][7:0])
            `CHK("ferr", ferr[k], 1'b0)
            `CHK("rx_last", rx_last[k], exp_cnt[k] ? msg_bytes : 16'h0000)
        end
    endtask
    task automatic track();
        sat_tracked <= 1'b1;
        @(posedge clk);
        sat_tracked <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, sec_tick, sat_tracked, cpu_alarm} = 4'h8;
        lock_period_s = 17'h00003;
        sync_period_s = 17'h00005;
        baud_sel = 8'h1B;
        fmt_sel = 12'h000;
        continuous = 2'h1;
        query_char = {8'(`TSP_DEF_QUERY_CHAR), 8'h3F};
        zone_offset = 10'h000;
        daylight_saving_rule = 4'h0;
        msg_bytes = 16'h5AC3;
        exp_cnt = '{0, 0, 0, 0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'hC)
        `CHK("txd", txd, 4'hF)
        tick(0);
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'hC)
        track();
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'h3)
        tick(0);
        tick(0);
        `CHK("alarms", {lock_supervision_alarm, sync_supervision_alarm}, 2'h0)
        tick(0);
        `CHK("alarms", {lock_supervision_alarm, sync_supervision_alarm}, 2'h2)
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'h9)
        g_far[1].u_far.send(8'h3F);
        tick(0);
        g_far[1].u_far.send(query_char[15:8]);
        tick(1);
        `CHK("alarms", {lock_supervision_alarm, sync_supervision_alarm}, 2'h3)
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'hC)
        track();
        cpu_alarm <= 1'b1;
        @(posedge clk);
        `CHK("lamps", {lock_lamp_red, sync_lamp_red, lock_lamp_green, sync_lamp_green}, 4'h9)
        cpu_alarm <= 1'b0;
        for (int f = 0; f < 6; f++) begin
            fmt_sel[2:0] <= 3'(f);
            zone_offset[4:0] <= 5'(f + 9);
            daylight_saving_rule[1:0] <= 2'(f);
            @(posedge clk);
            tick(0);
            `CHK("msg_fmt", msg_fmt[2:0], 3'(f))
            `CHK("msg_zone", {msg_zone[4:0], msg_dst[1:0]}, {5'(f + 9), 2'(f)})
        end
        summarize();
    end
endmodule
bind tsp_top tsp_top_sva #(.NPORT(NPORT), .N232(N232)) tsp_top_sva_inst (.clk, .rst,
    .sec_tick, .sat_tracked, .cpu_alarm, .continuous, .txd, .msg_active, .msg_fmt,
    .lock_lamp_green, .lock_lamp_red, .sync_lamp_green, .sync_lamp_red,
    .lock_supervision_alarm, .sync_supervision_alarm);
`default_nettype wire
